// File: hw/pss_defines.svh
// Purpose: Shared constants of the pipelined synchronous SRAM.
// Assumes: Included by bare name from the package and modules.
// Notes: Widths match the 256K x 36 organisation.
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// ==========================================================
// Array organisation
`define PSS_ADDR_W 18
`define PSS_DATA_W 36
`define PSS_BYTES 4
`define PSS_LANE_W 9
`define PSS_BURST_W 2

// ==========================================================
// Buffering and reset values
`define PSS_BUF_DEPTH 4
`define PSS_OE_IDLE 1'b1
`define PSS_CNT_RESET 2'h0

`endif

// File: hw/pss_pkg.sv
// Purpose: Types carried between the SRAM pipeline stages.
// Assumes: pss_defines.svh on the include path.
// Notes: None.
`include "pss_defines.svh"

package pss_pkg;

  // ==========================================================
  // Pipeline operation and buffered write beat
  typedef struct packed {
    logic vld;
    logic wr;
    logic [`PSS_ADDR_W-1:0] addr;
    logic [`PSS_BYTES-1:0] strbLow;
  } pss_op_t;

  typedef struct packed {
    logic [`PSS_ADDR_W-1:0] addr;
    logic [`PSS_BYTES-1:0] strbLow;
    logic [`PSS_DATA_W-1:0] data;
  } pss_wbeat_t;

endpackage : pss_pkg

// File: hw/pss_fifo.sv
// Purpose: Small flop-based FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty are exact; no write when full.
`timescale 1ns/1ps

module pss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_ff [DEPTH];
  logic [PW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [PW:0] count_ff, nxt_count;
  logic push, pop;

  // ==========================================================
  // Handshake and pointer update
  always_comb begin
    inReady = (count_ff != (PW+1)'(DEPTH));
    outValid = (count_ff != '0);
    outData = store_ff[rdPtr_ff];
    push = inValid && inReady;
    pop = outValid && outReady;
    nxt_wrPtr = push ? wrPtr_ff + PW'(1) : wrPtr_ff;
    nxt_rdPtr = pop ? rdPtr_ff + PW'(1) : rdPtr_ff;
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + (PW+1)'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - (PW+1)'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      store_ff[wrPtr_ff] <= inData;
    end
  end

endmodule : pss_fifo

// File: hw/pss_sram.sv
// Purpose: Pipelined synchronous burst SRAM, two-cycle data latency.
// Assumes: Controller runs on the same clock; inputs are synchronous.
// Notes: Write beats pass a small buffer before reaching the array.
`timescale 1ns/1ps
`include "pss_defines.svh"

module pss_sram
  import pss_pkg::*;
#(
  parameter int BUF_DEPTH = `PSS_BUF_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [`PSS_ADDR_W-1:0] address,
  input wire logic readNotWrite,
  input wire logic advanceOrLoad,
  input wire logic chipSelectFirstLow,
  input wire logic chipSelectSecondLow,
  input wire logic chipSelectActiveHigh,
  input wire logic clockGateLow,
  input wire logic [`PSS_BYTES-1:0] byteWriteStrobes,
  input wire logic burstOrderSelect,
  input wire logic [`PSS_DATA_W-1:0] dataIn,
  output logic [`PSS_DATA_W-1:0] dataOut,
  output logic dataOeLow,
  output logic writeBufferReady
);

  // ==========================================================
  // Decode helpers
  function automatic logic isSelected(input logic cs1Low,
                                      input logic cs2Low,
                                      input logic cs2High);
    isSelected = !cs1Low && !cs2Low && cs2High;
  endfunction : isSelected

  function automatic logic [`PSS_ADDR_W-1:0] beatAddr(
      input logic [`PSS_ADDR_W-1:0] base,
      input logic [`PSS_BURST_W-1:0] cnt,
      input logic interleaved);
    logic [`PSS_BURST_W-1:0] low;
    low = interleaved ? (base[`PSS_BURST_W-1:0] ^ cnt)
                      : (base[`PSS_BURST_W-1:0] + cnt);
    beatAddr = {base[`PSS_ADDR_W-1:`PSS_BURST_W], low};
  endfunction : beatAddr

  logic [`PSS_DATA_W-1:0] mem_ff [2**`PSS_ADDR_W];
  wire logic [`PSS_DATA_W-1:0] laneMask;

  pss_op_t s1_ff, nxt_s1, s2_ff, nxt_s2;
  logic active_ff, nxt_active, opWr_ff, nxt_opWr;
  logic [`PSS_ADDR_W-1:0] base_ff, nxt_base;
  logic [`PSS_BURST_W-1:0] cnt_ff, nxt_cnt;
  logic [`PSS_DATA_W-1:0] dout_ff, nxt_dout;
  logic oeLow_ff, nxt_oeLow;
  logic en, sel;
  logic pushValid, popValid, popReady;
  pss_wbeat_t pushBeat, popBeat;

  // ==========================================================
  // Command stage and burst counter
  always_comb begin
    en = !clockGateLow;
    sel = isSelected(chipSelectFirstLow, chipSelectSecondLow,
                     chipSelectActiveHigh);
    nxt_s1 = s1_ff;
    nxt_s2 = s2_ff;
    nxt_active = active_ff;
    nxt_opWr = opWr_ff;
    nxt_base = base_ff;
    nxt_cnt = cnt_ff;
    nxt_dout = dout_ff;
    nxt_oeLow = oeLow_ff;
    if (en) begin
      if (!advanceOrLoad) begin
        if (sel) begin
          nxt_active = 1'b1;
          nxt_opWr = !readNotWrite;
          nxt_base = address;
          nxt_cnt = `PSS_CNT_RESET;
          nxt_s1 = '{vld: 1'b1, wr: !readNotWrite, addr: address,
                     strbLow: byteWriteStrobes};
        end else begin
          nxt_active = 1'b0;
          nxt_s1.vld = 1'b0;
        end
      end else if (active_ff) begin
        nxt_cnt = cnt_ff + `PSS_BURST_W'(1);
        nxt_s1 = '{vld: 1'b1, wr: opWr_ff,
                   addr: beatAddr(base_ff, nxt_cnt, burstOrderSelect),
                   strbLow: byteWriteStrobes};
      end else begin
        nxt_s1.vld = 1'b0;
      end
      nxt_s2 = s1_ff;
      nxt_oeLow = !(s1_ff.vld && !s1_ff.wr);
      if (s1_ff.vld && !s1_ff.wr) begin
        nxt_dout = mem_ff[s1_ff.addr];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      active_ff <= 1'b0;
      opWr_ff <= 1'b0;
      base_ff <= '0;
      cnt_ff <= `PSS_CNT_RESET;
      dout_ff <= '0;
      oeLow_ff <= `PSS_OE_IDLE;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      active_ff <= nxt_active;
      opWr_ff <= nxt_opWr;
      base_ff <= nxt_base;
      cnt_ff <= nxt_cnt;
      dout_ff <= nxt_dout;
      oeLow_ff <= nxt_oeLow;
    end
  end

  assign dataOut = dout_ff;
  assign dataOeLow = oeLow_ff;

  // ==========================================================
  // Write beat capture and buffer
  always_comb begin
    pushValid = en && s2_ff.vld && s2_ff.wr;
    pushBeat = '{addr: s2_ff.addr, strbLow: s2_ff.strbLow,
                 data: dataIn};
    popReady = en;
  end

  pss_fifo #(
    .WIDTH($bits(pss_wbeat_t)),
    .DEPTH(BUF_DEPTH)
  ) u_wbuf (
    .clock(clock),
    .rst(rst),
    .inValid(pushValid),
    .inReady(writeBufferReady),
    .inData(pushBeat),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popBeat)
  );

  // ==========================================================
  // Array byte lanes
  for (genvar b = 0; b < `PSS_BYTES; b++) begin : g_lane
    assign laneMask[b*`PSS_LANE_W +: `PSS_LANE_W] =
      {`PSS_LANE_W{!popBeat.strbLow[b]}};
  end

  // One writer for the array, lanes merged by mask
  always_ff @(posedge clock) begin
    if (popValid && popReady) begin
      mem_ff[popBeat.addr] <= (mem_ff[popBeat.addr] & ~laneMask)
        | (popBeat.data & laneMask);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_rd_load;
    en && sel && !advanceOrLoad && readNotWrite;
  endsequence

  sequence s_wr_load;
    en && sel && !advanceOrLoad && !readNotWrite;
  endsequence

  property p_rd_latency;
    s_rd_load ##1 en |=> !dataOeLow;
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("read load did not drive bus after two enabled edges");

  property p_wr_capture;
    s_wr_load ##1 en ##1 en |-> pushValid;
  endproperty
  a_wr_capture: assert property (p_wr_capture)
    else $error("write beat not captured on data cycle");

  property p_new_load;
    en && sel && !advanceOrLoad |=>
      s1_ff.vld && s1_ff.addr == $past(address)
      && s1_ff.wr == !$past(readNotWrite);
  endproperty
  a_new_load: assert property (p_new_load)
    else $error("load not accepted in its own cycle");

  property p_linear_step;
    en && advanceOrLoad && active_ff && !burstOrderSelect |=>
      s1_ff.addr[1:0] == $past(s1_ff.addr[1:0]) + 2'h1;
  endproperty
  a_linear_step: assert property (p_linear_step)
    else $error("linear burst did not step address");

  property p_inter_wrap;
    en && advanceOrLoad && active_ff && burstOrderSelect |=>
      s1_ff.addr[1:0] == (base_ff[1:0] ^ cnt_ff);
  endproperty
  a_inter_wrap: assert property (p_inter_wrap)
    else $error("interleaved burst order wrong");

  property p_freeze;
    !en |=> $stable(s1_ff) && $stable(s2_ff) && $stable(dataOut)
      && $stable(dataOeLow);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("pipeline moved on a gated edge");

  property p_gated_latency;
    s_rd_load ##1 !en [*2] ##1 en |=> !dataOeLow;
  endproperty
  a_gated_latency: assert property (p_gated_latency)
    else $error("gated edges counted toward latency");

  sequence s_desel;
    en && !advanceOrLoad && !sel;
  endsequence

  // First enabled edge after a deselect floats the bus
  property p_deselect;
    s_desel ##1 en |=> dataOeLow;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselect did not float the bus");

  property p_reset_float;
    disable iff (1'b0) rst |=> dataOeLow;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("bus driven after reset");

endmodule : pss_sram

// File: verif/pss_ctrl_model.sv
// Purpose: Controller model driving write beats on dataIn.
// Assumes: Beat data comes with its command.
// Notes: Idle bus shows inverse of last beat.
`timescale 1ns/1ps
`include "pss_defines.svh"

module pss_ctrl_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockGateLow,
  input wire logic advanceOrLoad,
  input wire logic readNotWrite,
  input wire logic [2:0] selects,
  input wire logic [`PSS_DATA_W-1:0] beatData,
  output logic [`PSS_DATA_W-1:0] dataIn
);
  logic wr;
  logic burstWr_ff;
  logic [1:0] vld_ff;
  logic [`PSS_DATA_W-1:0] d1_ff, d2_ff, last_ff;

  assign wr = selects == 3'b001 && !readNotWrite;

  // ==========================================================
  // Beat pipeline
  // beats on enabled edges
  always_ff @(posedge clock) begin
    if (rst) begin
      vld_ff <= 2'h0;
      burstWr_ff <= 1'b0;
      last_ff <= '0;
    end else if (!clockGateLow) begin
      vld_ff <= {vld_ff[0], advanceOrLoad ? burstWr_ff : wr};
      if (!advanceOrLoad) begin
        burstWr_ff <= wr;
      end
      d1_ff <= beatData;
      d2_ff <= d1_ff;
      if (vld_ff[1]) begin
        last_ff <= d2_ff;
      end
    end
  end

  assign dataIn = vld_ff[1] ? d2_ff : ~last_ff;
endmodule : pss_ctrl_model

// File: verif/pss_sram_bench.sv
// Purpose: Self-checking bench of the pipelined SRAM.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Controller model supplies write beats.
`timescale 1ns/1ps
`include "pss_defines.svh"

module pss_sram_bench;
  localparam logic [`PSS_ADDR_W-1:0] BASE = 18'h100;
  logic clock, rst, rnw, adv, gateLow, bos, dataOeLow, wbr;
  logic [2:0] cs;
  logic [`PSS_ADDR_W-1:0] addr;
  logic [`PSS_BYTES-1:0] strb;
  logic [`PSS_DATA_W-1:0] wdat, dataIn, dataOut;
  int fails = 0;
  int compares = 0;

  pss_sram pss_sram_i (.clock(clock), .rst(rst), .address(addr),
    .readNotWrite(rnw), .advanceOrLoad(adv), .chipSelectFirstLow(cs[2]),
    .chipSelectSecondLow(cs[1]), .chipSelectActiveHigh(cs[0]),
    .clockGateLow(gateLow), .byteWriteStrobes(strb),
    .burstOrderSelect(bos), .dataIn(dataIn), .dataOut(dataOut),
    .dataOeLow(dataOeLow), .writeBufferReady(wbr));
  pss_ctrl_model pss_ctrl_model_i (.clock(clock), .rst(rst),
    .clockGateLow(gateLow), .advanceOrLoad(adv), .readNotWrite(rnw),
    .selects(cs), .beatData(wdat), .dataIn(dataIn));

  // ==========================================================
  // Bus cycles and compares
  task automatic drive(input logic a, r, input logic [2:0] c,
      input logic g, input logic [`PSS_ADDR_W-1:0] ad,
      input logic [`PSS_BYTES-1:0] s, input logic [`PSS_DATA_W-1:0] d);
    {adv, rnw, cs, gateLow, addr, strb, wdat} = {a, r, c, g, ad, s, d};
    @(posedge clock);
    #1;
  endtask : drive

  task automatic ld(input logic r, input logic [`PSS_ADDR_W-1:0] ad,
      input logic [`PSS_BYTES-1:0] s, input logic [`PSS_DATA_W-1:0] d);
    drive(1'b0, r, 3'b001, 1'b0, ad, s, d);
  endtask : ld

  task automatic av(input logic [`PSS_DATA_W-1:0] d);
    drive(1'b1, 1'b0, 3'b001, 1'b0, '0, 4'h0, d);
  endtask : av

  task automatic ds();
    drive(1'b0, 1'b0, 3'b101, 1'b0, '0, 4'hf, '0);
  endtask : ds

  // Selected write load while gated
  task automatic gt();
    drive(1'b0, 1'b0, 3'b001, 1'b1, 18'h200, 4'h0, '0);
  endtask : gt

  task automatic ckd(input string n, input logic [`PSS_DATA_W-1:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : ckd

  task automatic ckf(input string n, input logic e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask : ckf

  task automatic rd(input logic [`PSS_DATA_W-1:0] e);
    ckf("dataOeLow", 1'b0, dataOeLow);
    ckd("dataOut", e, dataOut);
  endtask : rd

  function automatic logic [`PSS_DATA_W-1:0] pat(input int x);
    return 36'h5a5a00000 + 36'(x);
  endfunction : pat

  // ==========================================================
  // Scenarios
  task automatic t_write_read();
    ld(1'b0, 18'h10, 4'h0, 36'h123456789);
    ld(1'b0, 18'h10, 4'he, 36'hfedcba987);
    repeat (3) ds();
    ld(1'b1, 18'h10, 4'hf, '0);
    ds();
    rd(36'h123456787);
    ds();
    ckf("dataOeLow", 1'b1, dataOeLow);
    bos = 1'b0;
    ld(1'b0, BASE, 4'h0, pat(0));
    for (int k = 1; k < 4; k++) begin
      av(pat(k));
    end
    repeat (3) ds();
    ckf("writeBufferReady", 1'b1, wbr);
    $display("test write_read done");
  endtask : t_write_read

  task automatic t_burst(input logic o, input int b);
    bos = o;
    for (int k = 0; k < 8; k++) begin
      if (k == 0) ld(1'b1, BASE + 18'(b), 4'hf, '0);
      else if (k < 6) av('0);
      else ds();
      if (k == 7) ckf("dataOeLow", 1'b1, dataOeLow);
      else if (k > 0) rd(pat(o ? (b ^ (k - 1)) % 4 : (b + k - 1) % 4));
    end
    $display("test burst done");
  endtask : t_burst

  task automatic t_b2b();
    logic [2:0] bad [3] = '{3'b101, 3'b011, 3'b000};
    bos = 1'b0;
    ld(1'b1, BASE, 4'hf, '0);
    av('0);
    rd(pat(0));
    ld(1'b1, BASE + 18'h3, 4'hf, '0);
    rd(pat(1));
    ds();
    rd(pat(3));
    foreach (bad[i]) begin
      drive(1'b0, 1'b1, bad[i], 1'b0, BASE, 4'hf, '0);
      ds();
      ckf("dataOeLow", 1'b1, dataOeLow);
    end
    $display("test b2b done");
  endtask : t_b2b

  task automatic t_gate();
    ld(1'b1, BASE, 4'hf, '0);
    gt();
    ld(1'b1, BASE + 18'h1, 4'hf, '0);
    rd(pat(0));
    repeat (2) begin
      gt();
      rd(pat(0));
    end
    ld(1'b1, BASE + 18'h2, 4'hf, '0);
    rd(pat(1));
    ds();
    rd(pat(2));
    ld(1'b0, 18'h200, 4'h0, 36'h0aaaa5555);
    gt();
    ld(1'b0, 18'h201, 4'h0, 36'h055550aaa);
    repeat (2) gt();
    repeat (3) ds();
    ld(1'b1, 18'h200, 4'hf, '0);
    ld(1'b1, 18'h201, 4'hf, '0);
    rd(36'h0aaaa5555);
    ds();
    rd(36'h055550aaa);
    $display("test gate done");
  endtask : t_gate

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    $display("[FAIL] watchdog expected 0 seen 1");
    results();
  end

  initial begin
    {adv, rnw, gateLow, bos, addr, strb, wdat} = '0;
    cs = 3'b101;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    ckf("dataOeLow", 1'b1, dataOeLow);
    t_write_read();
    t_burst(1'b0, 1);
    t_burst(1'b1, 2);
    t_b2b();
    t_gate();
    results();
  end
endmodule : pss_sram_bench
